// ===== common/bst_pkg.sv
// Shared constants, states and carriers for the boundary-scan test port
package bst_pkg;

	// ==========================================================
	// Instruction register
	localparam int          IR_W      = 16;
	localparam logic [15:0] OP_BYP0   = 16'h0000;
	localparam logic [15:0] OP_BYP1   = 16'hffff;
	localparam logic [15:0] OP_SAMPLE = 16'hfff8;
	localparam logic [15:0] OP_EXTEST = 16'hffe8;
	localparam logic [15:0] OP_CLAMP  = 16'hffef;
	localparam logic [15:0] OP_IDCODE = 16'hfffe;
	localparam logic [15:0] OP_HIGHZ  = 16'hffcf;
	// Fixed capture pattern, low two bits 01
	localparam logic [15:0] IR_CAPT   = 16'h0001;

	// ==========================================================
	// Identification
	localparam int          ID_W      = 32;
	// Arbitrary value; bit 0 must stay set
	localparam logic [31:0] ID_DEF    = 32'h0a5c_0001;

	// ==========================================================
	// Shared pin positions and scan cell layout
	localparam int         SH_W      = 4;
	localparam int         PIN_TCK   = 0;
	localparam int         PIN_TMS   = 1;
	localparam int         PIN_TDI   = 2;
	localparam int         PIN_TDO   = 3;
	localparam int         CELLS     = 3;
	localparam int         CELL_IN   = 0;
	localparam int         CELL_OUT  = 1;
	localparam int         CELL_OE   = 2;
	localparam logic [2:0] TMS_RESET = 3'h5;

	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		TAP_TLR, TAP_RTI,
		TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
		TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR,
		TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR,
		TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
	} bst_tap_e;

	typedef enum logic [1:0] {DR_BYP, DR_ID, DR_BSR} bst_dr_e;

	typedef struct packed {
		logic test_sel;
		logic tdi;
		logic tms;
		logic tck;
	} bst_pins_s;

	typedef struct packed {
		logic capture;
		logic shift;
		logic update;
		logic tdi;
		logic drive;
		logic highz;
	} bst_bsr_ctl_s;

endpackage

// ===== hdl/bst_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module bst_sync #(
	parameter int W = 4
) (
	// System
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Raw and filtered levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// ==========================================================
	// Stage one feeds stage two only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// A bit changes only once the last two stages agree
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2[i] == s3[i]) begin
					q[i] <= s3[i];
				end
			end
		end
	end
endmodule

// ===== hdl/bst_bsr.sv
// Boundary-scan register: one input, output and enable cell per pin
`timescale 1ns/1ns
module bst_bsr #(
	parameter int NUM_IO = 8
) (
	// System
	input  wire logic               clk,
	input  wire logic               rst_n,
	// Control from the test port
	input  bst_pkg::bst_bsr_ctl_s   ctl,
	output logic                    tdo_bit,
	// Core side
	input  wire logic [NUM_IO-1:0]  core_out,
	input  wire logic [NUM_IO-1:0]  core_oe,
	output logic      [NUM_IO-1:0]  core_in,
	// Pad side
	input  wire logic [NUM_IO-1:0]  pad_in,
	output logic      [NUM_IO-1:0]  pad_out,
	output logic      [NUM_IO-1:0]  pad_oe
);
	localparam int LEN = NUM_IO * bst_pkg::CELLS;

	logic [LEN-1:0] sh;
	logic [LEN-1:0] upd;

	// ==========================================================
	// Capture and shift stage
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sh <= '0;
		end else if (ctl.capture) begin
			for (int i = 0; i < NUM_IO; i++) begin
				sh[i*bst_pkg::CELLS+bst_pkg::CELL_IN]  <= pad_in[i];
				sh[i*bst_pkg::CELLS+bst_pkg::CELL_OUT] <= core_out[i];
				sh[i*bst_pkg::CELLS+bst_pkg::CELL_OE]  <= core_oe[i];
			end
		end else if (ctl.shift) begin
			sh <= {ctl.tdi, sh[LEN-1:1]};
		end
	end

	assign tdo_bit = sh[0];

	// Update latches hold preload values between scans
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			upd <= '0;
		end else if (ctl.update) begin
			upd <= sh;
		end
	end

	// ==========================================================
	// Pin mux; high-impedance wins over any drive
	always_comb begin
		core_in = pad_in;
		for (int i = 0; i < NUM_IO; i++) begin
			pad_out[i] = core_out[i];
			pad_oe[i]  = core_oe[i];
			if (ctl.drive) begin
				pad_out[i] = upd[i*bst_pkg::CELLS+bst_pkg::CELL_OUT];
				pad_oe[i]  = upd[i*bst_pkg::CELLS+bst_pkg::CELL_OE];
			end
			if (ctl.highz) begin
				pad_oe[i] = 1'b0;
			end
		end
	end

	// ==========================================================
	// Checks
	property p_highz;
		@(posedge clk) disable iff (!rst_n)
		ctl.highz |-> pad_oe == '0;
	endproperty
	a_highz: assert property (p_highz) else $error("Outputs driven in high-z mode");

	property p_drive;
		@(posedge clk) disable iff (!rst_n)
		ctl.drive && !ctl.highz |->
			pad_out[0] == upd[bst_pkg::CELL_OUT] && pad_oe[0] == upd[bst_pkg::CELL_OE];
	endproperty
	a_drive: assert property (p_drive) else $error("Pin not driven from update latch");

	property p_capture;
		@(posedge clk) disable iff (!rst_n)
		ctl.capture |=> sh[bst_pkg::CELL_IN] == $past(pad_in[0]);
	endproperty
	a_capture: assert property (p_capture) else $error("Pin input not captured");
endmodule

// ===== hdl/bst_tap.sv
// Boundary-scan test access port: state machine, instruction and data registers
`timescale 1ns/1ns
module bst_tap #(
	parameter int          NUM_IO  = 8,
	parameter logic [31:0] ID_CODE = bst_pkg::ID_DEF
) (
	// System
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	// Test select pin
	input  wire logic                     test_select,
	output logic                          test_active,
	// Shared pins: clock, mode select, serial in, serial out
	input  wire logic [bst_pkg::SH_W-1:0] sh_in,
	output logic      [bst_pkg::SH_W-1:0] sh_out,
	output logic      [bst_pkg::SH_W-1:0] sh_oe,
	// Normal functions of the shared pins
	input  wire logic [bst_pkg::SH_W-1:0] fn_out,
	input  wire logic [bst_pkg::SH_W-1:0] fn_oe,
	output logic      [bst_pkg::SH_W-1:0] fn_in,
	// Core side of the scanned pins
	input  wire logic [NUM_IO-1:0]        core_out,
	input  wire logic [NUM_IO-1:0]        core_oe,
	output logic      [NUM_IO-1:0]        core_in,
	// Pad side of the scanned pins
	input  wire logic [NUM_IO-1:0]        pad_in,
	output logic      [NUM_IO-1:0]        pad_out,
	output logic      [NUM_IO-1:0]        pad_oe
);
	// ==========================================================
	// Decoders
	function automatic bst_pkg::bst_dr_e f_dr_sel(input logic [15:0] op);
		case (op)
			bst_pkg::OP_IDCODE: f_dr_sel = bst_pkg::DR_ID;
			bst_pkg::OP_SAMPLE: f_dr_sel = bst_pkg::DR_BSR;
			bst_pkg::OP_EXTEST: f_dr_sel = bst_pkg::DR_BSR;
			default:            f_dr_sel = bst_pkg::DR_BYP;
		endcase
	endfunction

	function automatic logic f_known(input logic [15:0] op);
		f_known = op == bst_pkg::OP_BYP0 || op == bst_pkg::OP_BYP1
			|| op == bst_pkg::OP_SAMPLE || op == bst_pkg::OP_EXTEST
			|| op == bst_pkg::OP_CLAMP || op == bst_pkg::OP_IDCODE
			|| op == bst_pkg::OP_HIGHZ;
	endfunction

	// ==========================================================
	// Declarations
	logic [bst_pkg::SH_W-1:0]   sync_q;
	bst_pkg::bst_pins_s         p;
	logic                       tck_q;
	logic                       tck_rise;
	logic                       tck_fall;
	bst_pkg::bst_tap_e          state;
	bst_pkg::bst_tap_e          next_state;
	logic [bst_pkg::IR_W-1:0]   ir;
	logic [bst_pkg::IR_W-1:0]   ir_sh;
	bst_pkg::bst_dr_e           dr_sel;
	logic                       bypass;
	logic [bst_pkg::ID_W-1:0]   id_sh;
	logic                       bsr_tdo;
	logic                       dr_bit;
	logic                       tdo;
	logic                       tdo_en;
	bst_pkg::bst_bsr_ctl_s      bctl;
	logic [2:0]                 ones_cnt;

	// ==========================================================
	// Pin synchronisers; the link clock is a sampled level here
	bst_sync #(
		.W (bst_pkg::SH_W)
	) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({test_select, sh_in[bst_pkg::PIN_TDI],
		         sh_in[bst_pkg::PIN_TMS], sh_in[bst_pkg::PIN_TCK]}),
		.q     (sync_q)
	);

	assign p           = bst_pkg::bst_pins_s'(sync_q);
	assign test_active = p.test_sel;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tck_q <= 1'b0;
		end else begin
			tck_q <= p.tck;
		end
	end

	// Edges are found in the same system clock that the filtered level moves
	assign tck_rise = p.tck & ~tck_q;
	assign tck_fall = ~p.tck & tck_q;

	// ==========================================================
	// TAP state machine
	always_comb begin
		case (state)
			bst_pkg::TAP_TLR:    next_state = p.tms ? bst_pkg::TAP_TLR : bst_pkg::TAP_RTI;
			bst_pkg::TAP_RTI:    next_state = p.tms ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_RTI;
			bst_pkg::TAP_SEL_DR: next_state = p.tms ? bst_pkg::TAP_SEL_IR : bst_pkg::TAP_CAP_DR;
			bst_pkg::TAP_CAP_DR: next_state = p.tms ? bst_pkg::TAP_EX1_DR : bst_pkg::TAP_SH_DR;
			bst_pkg::TAP_SH_DR:  next_state = p.tms ? bst_pkg::TAP_EX1_DR : bst_pkg::TAP_SH_DR;
			bst_pkg::TAP_EX1_DR: next_state = p.tms ? bst_pkg::TAP_UPD_DR : bst_pkg::TAP_PA_DR;
			bst_pkg::TAP_PA_DR:  next_state = p.tms ? bst_pkg::TAP_EX2_DR : bst_pkg::TAP_PA_DR;
			bst_pkg::TAP_EX2_DR: next_state = p.tms ? bst_pkg::TAP_UPD_DR : bst_pkg::TAP_SH_DR;
			bst_pkg::TAP_UPD_DR: next_state = p.tms ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_RTI;
			bst_pkg::TAP_SEL_IR: next_state = p.tms ? bst_pkg::TAP_TLR : bst_pkg::TAP_CAP_IR;
			bst_pkg::TAP_CAP_IR: next_state = p.tms ? bst_pkg::TAP_EX1_IR : bst_pkg::TAP_SH_IR;
			bst_pkg::TAP_SH_IR:  next_state = p.tms ? bst_pkg::TAP_EX1_IR : bst_pkg::TAP_SH_IR;
			bst_pkg::TAP_EX1_IR: next_state = p.tms ? bst_pkg::TAP_UPD_IR : bst_pkg::TAP_PA_IR;
			bst_pkg::TAP_PA_IR:  next_state = p.tms ? bst_pkg::TAP_EX2_IR : bst_pkg::TAP_PA_IR;
			bst_pkg::TAP_EX2_IR: next_state = p.tms ? bst_pkg::TAP_UPD_IR : bst_pkg::TAP_SH_IR;
			bst_pkg::TAP_UPD_IR: next_state = p.tms ? bst_pkg::TAP_SEL_DR : bst_pkg::TAP_RTI;
			default:             next_state = bst_pkg::TAP_TLR;
		endcase
	end

	// Held in reset whenever test selection is off
	always_ff @(posedge clk) begin
		if (!rst_n || !p.test_sel) begin
			state <= bst_pkg::TAP_TLR;
		end else if (tck_rise) begin
			state <= next_state;
		end
	end

	// ==========================================================
	// Instruction register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ir_sh <= '0;
		end else if (tck_rise && state == bst_pkg::TAP_CAP_IR) begin
			ir_sh <= bst_pkg::IR_CAPT;
		end else if (tck_rise && state == bst_pkg::TAP_SH_IR) begin
			ir_sh <= {p.tdi, ir_sh[bst_pkg::IR_W-1:1]};
		end
	end

	// New opcode takes effect on the falling edge in update
	always_ff @(posedge clk) begin
		if (!rst_n || state == bst_pkg::TAP_TLR) begin
			ir <= bst_pkg::OP_IDCODE;
		end else if (tck_fall && state == bst_pkg::TAP_UPD_IR) begin
			ir <= ir_sh;
		end
	end

	assign dr_sel = f_dr_sel(ir);

	// ==========================================================
	// Bypass and identification registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bypass <= 1'b0;
		end else if (tck_rise && state == bst_pkg::TAP_CAP_DR) begin
			bypass <= 1'b0;
		end else if (tck_rise && state == bst_pkg::TAP_SH_DR) begin
			bypass <= p.tdi;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			id_sh <= '0;
		end else if (tck_rise && state == bst_pkg::TAP_CAP_DR) begin
			id_sh <= ID_CODE;
		end else if (tck_rise && state == bst_pkg::TAP_SH_DR) begin
			id_sh <= {p.tdi, id_sh[bst_pkg::ID_W-1:1]};
		end
	end

	// ==========================================================
	// Boundary-scan register
	always_comb begin
		bctl.capture = tck_rise && state == bst_pkg::TAP_CAP_DR && dr_sel == bst_pkg::DR_BSR;
		bctl.shift   = tck_rise && state == bst_pkg::TAP_SH_DR && dr_sel == bst_pkg::DR_BSR;
		bctl.update  = tck_fall && state == bst_pkg::TAP_UPD_DR && dr_sel == bst_pkg::DR_BSR;
		bctl.tdi     = p.tdi;
		bctl.drive   = ir == bst_pkg::OP_EXTEST || ir == bst_pkg::OP_CLAMP;
		bctl.highz   = ir == bst_pkg::OP_HIGHZ;
	end

	bst_bsr #(
		.NUM_IO (NUM_IO)
	) u_bsr (
		.clk      (clk),
		.rst_n    (rst_n),
		.ctl      (bctl),
		.tdo_bit  (bsr_tdo),
		.core_out (core_out),
		.core_oe  (core_oe),
		.core_in  (core_in),
		.pad_in   (pad_in),
		.pad_out  (pad_out),
		.pad_oe   (pad_oe)
	);

	// ==========================================================
	// Serial output
	always_comb begin
		case (dr_sel)
			bst_pkg::DR_ID:  dr_bit = id_sh[0];
			bst_pkg::DR_BSR: dr_bit = bsr_tdo;
			default:         dr_bit = bypass;
		endcase
	end

	// Tester samples just before the next falling edge, so hold over the whole low and high phases
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tdo    <= 1'b0;
			tdo_en <= 1'b0;
		end else if (!p.test_sel) begin
			// Deselect in mid-shift must release serial out at once
			tdo_en <= 1'b0;
		end else if (tck_fall) begin
			tdo_en <= state == bst_pkg::TAP_SH_IR || state == bst_pkg::TAP_SH_DR;
			tdo    <= state == bst_pkg::TAP_SH_IR ? ir_sh[0] : dr_bit;
		end
	end

	// ==========================================================
	// Shared pin mux
	always_comb begin
		sh_out = fn_out;
		sh_oe  = fn_oe;
		fn_in  = sh_in;
		if (p.test_sel) begin
			sh_out                   = '0;
			sh_oe                    = '0;
			fn_in                    = '0;
			sh_out[bst_pkg::PIN_TDO] = tdo;
			sh_oe[bst_pkg::PIN_TDO]  = tdo_en;
		end
	end

	// ==========================================================
	// Checks
	always_ff @(posedge clk) begin
		if (!rst_n || !p.test_sel) begin
			ones_cnt <= '0;
		end else if (tck_rise) begin
			if (!p.tms) begin
				ones_cnt <= '0;
			end else if (ones_cnt != bst_pkg::TMS_RESET) begin
				ones_cnt <= ones_cnt + 3'h1;
			end
		end
	end

	sequence s_state_moved;
		$changed(state) && $past(p.test_sel);
	endsequence

	property p_rise_only;
		@(posedge clk) disable iff (!rst_n)
		s_state_moved |-> $past(tck_rise);
	endproperty
	a_rise_only: assert property (p_rise_only) else $error("State moved off a rising edge");

	property p_tdo_fall;
		@(posedge clk) disable iff (!rst_n)
		$changed(tdo) |-> $past(tck_fall);
	endproperty
	a_tdo_fall: assert property (p_tdo_fall) else $error("Serial out moved off a falling edge");

	property p_inactive;
		@(posedge clk) disable iff (!rst_n)
		!p.test_sel |=> state == bst_pkg::TAP_TLR && !tdo_en;
	endproperty
	a_inactive: assert property (p_inactive) else $error("Port active without test select");

	property p_pin_mux;
		@(posedge clk) disable iff (!rst_n)
		!p.test_sel |-> sh_out == fn_out && sh_oe == fn_oe && fn_in == sh_in;
	endproperty
	a_pin_mux: assert property (p_pin_mux) else $error("Shared pins not in normal use");

	sequence s_bypass_shift;
		tck_rise && state == bst_pkg::TAP_SH_DR
			&& (ir == bst_pkg::OP_BYP0 || ir == bst_pkg::OP_BYP1);
	endsequence

	property p_bypass;
		@(posedge clk) disable iff (!rst_n)
		s_bypass_shift |=> bypass == $past(p.tdi);
	endproperty
	a_bypass: assert property (p_bypass) else $error("Bypass bit not shifted");

	property p_unknown;
		@(posedge clk) disable iff (!rst_n)
		!f_known(ir) |-> dr_sel == bst_pkg::DR_BYP;
	endproperty
	a_unknown: assert property (p_unknown) else $error("Unknown opcode not bypassed");

	property p_id_capture;
		@(posedge clk) disable iff (!rst_n)
		tck_rise && state == bst_pkg::TAP_CAP_DR && ir == bst_pkg::OP_IDCODE
			|=> id_sh == ID_CODE;
	endproperty
	a_id_capture: assert property (p_id_capture) else $error("Id code not captured");

	property p_five_ones;
		@(posedge clk) disable iff (!rst_n)
		ones_cnt == bst_pkg::TMS_RESET |-> state == bst_pkg::TAP_TLR ##1 ir == bst_pkg::OP_IDCODE;
	endproperty
	a_five_ones: assert property (p_five_ones) else $error("No reset after five ones");
endmodule

// ===== testbench/bst_tester.sv
// Board tester model that drives the test port pins
`timescale 1ns/1ns
module bst_tester (
	// System
	input  wire logic  clk,
	// Serial out as seen on the board
	input  wire logic  tdo,
	// Driven pins: select, then data, mode and test clock
	output logic       test_select,
	output logic [2:0] drv
);
	// ==========================================================
	// Pin drive
	initial begin
		test_select = 1'b0;
		drv = 3'h0;
	end

	// Select is raised and settled before any clock activity
	task automatic sel(input logic v);
		@(posedge clk) test_select <= v;
		repeat (8) @(posedge clk);
	endtask

	// One 800 ns test clock cycle; the clock idles low between cycles.
	// Serial out is read just before the fall, eight cycles after the
	// previous fall, since the port answers five cycles after a fall.
	task automatic cyc(input logic tms, input logic tdi, output logic tdo_bit);
		@(posedge clk) drv <= {tdi, tms, 1'b0};
		repeat (3) @(posedge clk);
		drv[0] <= 1'b1;
		repeat (4) @(posedge clk);
		tdo_bit = tdo;
		drv[0] <= 1'b0;
	endtask
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ns
module testbench;
	// ==========================================================
	// Clock, pins and counters
	localparam logic [31:0] ID  = 32'h1234_5679; // Arbitrary value, bit 0 set
	localparam logic [7:0]  PO  = 8'ha5;
	localparam logic [7:0]  POE = 8'h0f;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        flt = 1'b0;
	logic        test_select;
	logic        test_active;
	logic [2:0]  drv;
	logic [3:0]  pin;
	logic [3:0]  sh_out;
	logic [3:0]  sh_oe;
	logic [3:0]  fn_in;
	logic [3:0]  fn_out = 4'h5;
	logic [3:0]  fn_oe = 4'h8;
	logic [7:0]  core_out = 8'h5a;
	logic [7:0]  core_oe = 8'hc3;
	logic [7:0]  pad_in = 8'h3c;
	logic [7:0]  core_in;
	logic [7:0]  pad_out;
	logic [7:0]  pad_oe;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	always #50 clk = ~clk;
	// A released serial out toggles so a stale level never passes for data
	always @(posedge clk) flt <= ~flt;
	assign pin = {sh_oe[3] ? sh_out[3] : flt, (sh_oe[2:0] & sh_out[2:0]) | (~sh_oe[2:0] & drv)};

	bst_tap #(.NUM_IO(8), .ID_CODE(ID)) bst_tap_i (
		.clk(clk), .rst_n(rst_n), .test_select(test_select), .test_active(test_active),
		.sh_in(pin), .sh_out(sh_out), .sh_oe(sh_oe), .fn_out(fn_out), .fn_oe(fn_oe),
		.fn_in(fn_in), .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
	bst_tester bst_tester_i (.clk(clk), .tdo(pin[3]), .test_select(test_select), .drv(drv));

	// ==========================================================
	// Shared tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict;
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	function automatic logic [31:0] pack(input logic [7:0] a, b, c);
		pack = '0;
		for (int i = 0; i < 8; i++) begin
			pack[3*i] = a[i];
			pack[3*i+1] = b[i];
			pack[3*i+2] = c[i];
		end
	endfunction

	task automatic walk(input logic [7:0] tms, input int n);
		logic b;
		for (int i = 0; i < n; i++) begin
			bst_tester_i.cyc(tms[i], 1'b0, b);
		end
	endtask

	// From idle: select, capture, n shifts, update, back to idle
	task automatic scan(input logic ir, input logic [31:0] din, input int n,
		output logic [31:0] dout);
		logic b;
		dout = '0;
		walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
		for (int j = 0; j < n; j++) begin
			bst_tester_i.cyc(j == n - 1, din[j], b);
			dout[j] = b;
		end
		walk(8'h01, 2);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_normal;
		logic [31:0] d;
		walk(8'h1f, 6);
		scan(1'b1, 32'hffe8, 16, d);
		repeat (8) @(posedge clk);
		check("active", test_active, 0);
		check("fn_in", fn_in, pin);
		check("sh_out", sh_out, fn_out);
		check("sh_oe", sh_oe, fn_oe);
		check("pad_out", pad_out, core_out);
		check("pad_oe", pad_oe, core_oe);
		check("core_in", core_in, pad_in);
	endtask

	task automatic t_enable;
		logic [31:0] d;
		bst_tester_i.sel(1'b1);
		check("active", test_active, 1);
		check("fn_in", fn_in, 0);
		check("sh_oe", sh_oe, 0);
		check("sh_out", sh_out, 0);
		walk(8'h00, 1);
		scan(1'b0, 32'h0, 32, d);
		check("idcode", d, ID);
	endtask

	task automatic t_tms_reset;
		logic [31:0] d;
		scan(1'b1, 32'hffff, 16, d);
		check("ir capture", d, 32'h1);
		walk(8'h1f, 6);
		scan(1'b0, 32'h0, 32, d);
		check("idcode", d, ID);
	endtask

	task automatic t_sample;
		logic [31:0] d;
		scan(1'b1, 32'hfff8, 16, d);
		scan(1'b0, pack(8'h00, PO, POE), 24, d);
		check("sample", d, pack(pad_in, core_out, core_oe));
		check("pad_out", pad_out, core_out);
		check("pad_oe", pad_oe, core_oe);
	endtask

	task automatic t_extest;
		logic [31:0] d;
		scan(1'b1, 32'hffe8, 16, d);
		check("ext out", pad_out, PO);
		check("ext oe", pad_oe, POE);
		@(posedge clk) pad_in <= 8'h96;
		scan(1'b0, pack(8'h00, PO, POE), 24, d);
		check("ext in", d & pack(8'hff, 8'h0, 8'h0), pack(8'h96, 8'h0, 8'h0));
		check("core_in", core_in, 8'h96);
	endtask

	// Clamp keeps the preloaded latch, high impedance floats, all bypass
	task automatic t_bypass;
		logic [31:0] d;
		logic [15:0] ops [5] = '{16'h0000, 16'hffff, 16'h1234, 16'hffef, 16'hffcf};
		logic [7:0]  eoe;
		for (int k = 0; k < 5; k++) begin
			scan(1'b1, {16'h0, ops[k]}, 16, d);
			check("ir capture", d, 32'h1);
			check("byp out", pad_out, ops[k] == 16'hffef ? PO : core_out);
			eoe = ops[k] == 16'hffcf ? 8'h00 : core_oe;
			check("byp oe", pad_oe, ops[k] == 16'hffef ? POE : eoe);
			scan(1'b0, 32'h0000_b5a3, 17, d);
			check("bypass", d, 32'h0001_6b46);
		end
	endtask

	task automatic t_deselect;
		logic [31:0] d;
		scan(1'b1, 32'hffe8, 16, d);
		// Drop select on entering shift, before serial out is enabled
		walk(8'h01, 3);
		bst_tester_i.sel(1'b0);
		check("active", test_active, 0);
		check("pad_out", pad_out, core_out);
		check("sh_out", sh_out, fn_out);
		check("sh_oe", sh_oe, fn_oe);
	endtask

	// ==========================================================
	// Main sequence and hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_normal();
		t_enable();
		t_tms_reset();
		t_sample();
		t_extest();
		t_bypass();
		t_deselect();
		give_verdict();
	end
endmodule
